/* File: verilog/fpgio_consts.svh */
`ifndef FPGIO_CONSTS_SVH
`define FPGIO_CONSTS_SVH

// register byte addresses
`define FPGIO_ADDR_PIN_DIR 32'hFFF7FA00
`define FPGIO_ADDR_PIN_LEVEL 32'hFFF7FA04
`define FPGIO_ADDR_PIN_OUT 32'hFFF7FA08
`define FPGIO_ADDR_PIN_IRQ_EN 32'hFFF7FA14
`define FPGIO_ADDR_PIN_EDGE 32'hFFF7FA18
`define FPGIO_ADDR_PIN_PEND 32'hFFF7FA1C
`define FPGIO_ADDR_EXT_DIR 32'hFFF7FA20
`define FPGIO_ADDR_EXT_LEVEL 32'hFFF7FA24
`define FPGIO_ADDR_EXT_OUT 32'hFFF7FA28
`define FPGIO_ADDR_EXT_IRQ_EN 32'hFFF7FA34
`define FPGIO_ADDR_EXT_EDGE 32'hFFF7FA38
`define FPGIO_ADDR_EXT_PEND 32'hFFF7FA3C

// field layout
`define FPGIO_PROTECT_LSB 0
`define FPGIO_GENERAL_LSB 4
`define FPGIO_EXT_BIT 8
`define FPGIO_NUM_SENSED 9

// reset values
`define FPGIO_RST_BYTE 8'h00
`define FPGIO_RST_BIT 1'b0

`endif

/* File: verilog/fpgio_pkg.sv */
`default_nettype none

package fpgio_pkg;
    typedef logic [7:0] fpgio_byte_t;
    typedef logic [8:0] fpgio_sensed_t;
    typedef enum logic [1:0] {
        FPGIO_RESP_OKAY = 2'b00,
        FPGIO_RESP_SLVERR = 2'b10
    } fpgio_resp_t;
endpackage

`default_nettype wire

/* File: verilog/fpgio_reg_if.sv */
`default_nettype none

interface fpgio_reg_if;
    logic wr_req;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;

    modport bus (
        output wr_req, wr_addr, wr_data, wr_strb, rd_addr,
        input wr_err, rd_data, rd_err
    );
    modport regs (
        input wr_req, wr_addr, wr_data, wr_strb, rd_addr,
        output wr_err, rd_data, rd_err
    );
endinterface

`default_nettype wire

/* File: verilog/fpgio_pin_sync.sv */
`include "fpgio_consts.svh"

`default_nettype none

module fpgio_pin_sync
    import fpgio_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // raw pins and sensed results
    input wire fpgio_sensed_t level_i,
    output fpgio_sensed_t level_o,
    output fpgio_sensed_t rise_o,
    output fpgio_sensed_t fall_o
);

    for (genvar i = 0; i < `FPGIO_NUM_SENSED; i++) begin : g_bit
        logic meta;
        logic stable;
        logic prev;

        // meta feeds only stable
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                meta <= 1'b0;
                stable <= 1'b0;
                prev <= 1'b0;
            end else begin
                meta <= level_i[i];
                stable <= meta;
                prev <= stable;
            end
        end

        // one pulse per settled edge
        assign level_o[i] = stable;
        assign rise_o[i] = stable & ~prev;
        assign fall_o[i] = ~stable & prev;
    end

endmodule // fpgio_pin_sync

`default_nettype wire

/* File: verilog/fpgio_axil_slave.sv */
`default_nettype none

module fpgio_axil_slave
    import fpgio_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // write address and data
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // read
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // register side
    fpgio_reg_if.bus rf
);

    logic aw_full;
    logic w_full;
    logic rd_pend;

    // address and data in either order; response once both are held
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= FPGIO_RESP_OKAY;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            rf.wr_req <= 1'b0;
            rf.wr_addr <= 32'h00000000;
            rf.wr_data <= 32'h00000000;
            rf.wr_strb <= 4'h0;
        end else begin
            rf.wr_req <= 1'b0;
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                rf.wr_addr <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
                aw_full <= 1'b1;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                rf.wr_data <= s_axi_wdata_i;
                rf.wr_strb <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
                w_full <= 1'b1;
            end
            if (aw_full && w_full) begin
                rf.wr_req <= 1'b1;
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= rf.wr_err ? FPGIO_RESP_SLVERR : FPGIO_RESP_OKAY;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // read data captured one edge after the address
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= FPGIO_RESP_OKAY;
            rd_pend <= 1'b0;
            rf.rd_addr <= 32'h00000000;
        end else begin
            rd_pend <= 1'b0;
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                rf.rd_addr <= s_axi_araddr_i;
                s_axi_arready_o <= 1'b0;
                rd_pend <= 1'b1;
            end
            if (rd_pend) begin
                s_axi_rdata_o <= rf.rd_data;
                s_axi_rresp_o <= rf.rd_err ? FPGIO_RESP_SLVERR : FPGIO_RESP_OKAY;
                s_axi_rvalid_o <= 1'b1;
            end
            if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
                s_axi_arready_o <= 1'b1;
            end
        end
    end

endmodule // fpgio_axil_slave

`default_nettype wire

/* File: verilog/fpgio_top.sv */
// Summary of operation
// - registers word aligned; byte lane writes update only the addressed byte
// - all registers readable, writable registers accept writes without privilege checks
// - direction bits 7..4 make general pins D..A outputs in general mode
// - direction bits 3..0 make protect pins 3..0 outputs when set
// - level register returns general pins D..A in 7..4, protect pins in 3..0
// - output bits 7..4 drive general pins while output in general mode
// - output bits 3..0 drive protect pins while configured as output
// - per-pin enables, reset off; general pins need general mode
// - per-pin edge select: 0 falling, 1 rising, reset falling
// - pending bit sets on the selected edge of an enabled pin and stays until cleared
// - writing 1 clears a pending bit, writing 0 leaves it
// - external pin direction bit: 0 input, 1 output
// - external pin level readable in bit 0
// - external pin output value drives the pin while output
// - external pin interrupt enable, reset off
// - external pin edge select: 0 falling, 1 rising
// - external pin pending bit sets on its edge while enabled, holds until cleared
`include "fpgio_consts.svh"

`default_nettype none

module fpgio_top
    import fpgio_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // protect pins 3..0
    input wire logic [3:0] protect_pin_level_i,
    output logic [3:0] protect_pin_drive_o,
    output logic [3:0] protect_pin_oe_o,
    // general pins d..a in bits 3..0
    input wire logic [3:0] general_pin_level_i,
    input wire logic [3:0] general_pin_gp_mode_i,
    output logic [3:0] general_pin_drive_o,
    output logic [3:0] general_pin_oe_o,
    // external interrupt pin
    input wire logic external_irq_pin_level_i,
    output logic external_irq_pin_drive_o,
    output logic external_irq_pin_oe_o,
    // interrupt request
    output logic irq_o
);

    fpgio_reg_if rf ();

    // software state
    fpgio_byte_t pin_direction;
    fpgio_byte_t pin_output_value;
    fpgio_byte_t pin_irq_enable;
    fpgio_byte_t pin_irq_edge_select;
    fpgio_byte_t pin_irq_pending;
    logic ext_pin_direction;
    logic ext_pin_output_value;
    logic ext_pin_irq_enable;
    logic ext_pin_irq_edge_select;
    logic ext_pin_irq_pending;

    // sensed pins
    fpgio_sensed_t raw_level;
    fpgio_sensed_t sensed_level;
    fpgio_sensed_t sensed_rise;
    fpgio_sensed_t sensed_fall;

    // pending machinery
    fpgio_sensed_t edge_polarity;
    fpgio_sensed_t edge_hit;
    fpgio_sensed_t irq_allowed;
    fpgio_sensed_t pend_clear;
    fpgio_sensed_t pend_all;
    fpgio_sensed_t enable_all;
    fpgio_sensed_t next_pend_all;

    // decoded writes
    logic wr_lane0;
    logic wr_pin_dir;
    logic wr_pin_out;
    logic wr_pin_en;
    logic wr_pin_edge;
    logic wr_pin_pend;
    logic wr_ext_dir;
    logic wr_ext_out;
    logic wr_ext_en;
    logic wr_ext_edge;
    logic wr_ext_pend;
    logic [7:0] wr_byte;

    // bus slave
    fpgio_axil_slave u_bus (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .s_axi_awaddr_i(s_axi_awaddr_i),
        .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o),
        .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i),
        .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o),
        .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o),
        .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i),
        .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o),
        .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o),
        .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i),
        .rf(rf.bus)
    );

    // pin synchroniser and edge detect
    assign raw_level = {external_irq_pin_level_i, general_pin_level_i, protect_pin_level_i};

    fpgio_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .level_i(raw_level),
        .level_o(sensed_level),
        .rise_o(sensed_rise),
        .fall_o(sensed_fall)
    );

    // write decode; registers are at most 8 bits wide so only lane 0 carries data
    assign wr_lane0 = rf.wr_req & rf.wr_strb[0];
    assign wr_byte = rf.wr_data[7:0];
    assign wr_pin_dir = wr_lane0 && (rf.wr_addr == `FPGIO_ADDR_PIN_DIR);
    assign wr_pin_out = wr_lane0 && (rf.wr_addr == `FPGIO_ADDR_PIN_OUT);
    assign wr_pin_en = wr_lane0 && (rf.wr_addr == `FPGIO_ADDR_PIN_IRQ_EN);
    assign wr_pin_edge = wr_lane0 && (rf.wr_addr == `FPGIO_ADDR_PIN_EDGE);
    assign wr_pin_pend = wr_lane0 && (rf.wr_addr == `FPGIO_ADDR_PIN_PEND);
    assign wr_ext_dir = wr_lane0 && (rf.wr_addr == `FPGIO_ADDR_EXT_DIR);
    assign wr_ext_out = wr_lane0 && (rf.wr_addr == `FPGIO_ADDR_EXT_OUT);
    assign wr_ext_en = wr_lane0 && (rf.wr_addr == `FPGIO_ADDR_EXT_IRQ_EN);
    assign wr_ext_edge = wr_lane0 && (rf.wr_addr == `FPGIO_ADDR_EXT_EDGE);
    assign wr_ext_pend = wr_lane0 && (rf.wr_addr == `FPGIO_ADDR_EXT_PEND);

    // unmapped addresses answer with an error; level registers ignore writes
    always_comb begin
        unique case (rf.wr_addr)
            `FPGIO_ADDR_PIN_DIR,
            `FPGIO_ADDR_PIN_LEVEL,
            `FPGIO_ADDR_PIN_OUT,
            `FPGIO_ADDR_PIN_IRQ_EN,
            `FPGIO_ADDR_PIN_EDGE,
            `FPGIO_ADDR_PIN_PEND,
            `FPGIO_ADDR_EXT_DIR,
            `FPGIO_ADDR_EXT_LEVEL,
            `FPGIO_ADDR_EXT_OUT,
            `FPGIO_ADDR_EXT_IRQ_EN,
            `FPGIO_ADDR_EXT_EDGE,
            `FPGIO_ADDR_EXT_PEND: rf.wr_err = 1'b0;
            default: rf.wr_err = 1'b1;
        endcase
    end

    // read mux; bits above the register width read as zero
    always_comb begin
        rf.rd_err = 1'b0;
        unique case (rf.rd_addr)
            `FPGIO_ADDR_PIN_DIR: rf.rd_data = {24'h000000, pin_direction};
            `FPGIO_ADDR_PIN_LEVEL: rf.rd_data = {24'h000000, sensed_level[7:0]};
            `FPGIO_ADDR_PIN_OUT: rf.rd_data = {24'h000000, pin_output_value};
            `FPGIO_ADDR_PIN_IRQ_EN: rf.rd_data = {24'h000000, pin_irq_enable};
            `FPGIO_ADDR_PIN_EDGE: rf.rd_data = {24'h000000, pin_irq_edge_select};
            `FPGIO_ADDR_PIN_PEND: rf.rd_data = {24'h000000, pin_irq_pending};
            `FPGIO_ADDR_EXT_DIR: rf.rd_data = {31'h00000000, ext_pin_direction};
            `FPGIO_ADDR_EXT_LEVEL: rf.rd_data = {31'h00000000, sensed_level[`FPGIO_EXT_BIT]};
            `FPGIO_ADDR_EXT_OUT: rf.rd_data = {31'h00000000, ext_pin_output_value};
            `FPGIO_ADDR_EXT_IRQ_EN: rf.rd_data = {31'h00000000, ext_pin_irq_enable};
            `FPGIO_ADDR_EXT_EDGE: rf.rd_data = {31'h00000000, ext_pin_irq_edge_select};
            `FPGIO_ADDR_EXT_PEND: rf.rd_data = {31'h00000000, ext_pin_irq_pending};
            default: begin
                rf.rd_data = 32'h00000000;
                rf.rd_err = 1'b1;
            end
        endcase
    end

    // direction registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_direction <= `FPGIO_RST_BYTE;
            ext_pin_direction <= `FPGIO_RST_BIT;
        end else begin
            if (wr_pin_dir) begin
                pin_direction <= wr_byte;
            end
            if (wr_ext_dir) begin
                ext_pin_direction <= wr_byte[0];
            end
        end
    end

    // output value registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_output_value <= `FPGIO_RST_BYTE;
            ext_pin_output_value <= `FPGIO_RST_BIT;
        end else begin
            if (wr_pin_out) begin
                pin_output_value <= wr_byte;
            end
            if (wr_ext_out) begin
                ext_pin_output_value <= wr_byte[0];
            end
        end
    end

    // interrupt enables
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_irq_enable <= `FPGIO_RST_BYTE;
            ext_pin_irq_enable <= `FPGIO_RST_BIT;
        end else begin
            if (wr_pin_en) begin
                pin_irq_enable <= wr_byte;
            end
            if (wr_ext_en) begin
                ext_pin_irq_enable <= wr_byte[0];
            end
        end
    end

    // edge selects
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_irq_edge_select <= `FPGIO_RST_BYTE;
            ext_pin_irq_edge_select <= `FPGIO_RST_BIT;
        end else begin
            if (wr_pin_edge) begin
                pin_irq_edge_select <= wr_byte;
            end
            if (wr_ext_edge) begin
                ext_pin_irq_edge_select <= wr_byte[0];
            end
        end
    end

    // edge qualification across all nine sensed pins
    assign edge_polarity = {ext_pin_irq_edge_select, pin_irq_edge_select};
    assign edge_hit = (edge_polarity & sensed_rise) | (~edge_polarity & sensed_fall);

    // a general pin taken over by the pin mux raises nothing
    assign irq_allowed = {
        ext_pin_irq_enable,
        pin_irq_enable[7:4] & general_pin_gp_mode_i,
        pin_irq_enable[3:0]
    };

    assign pend_clear = {
        wr_ext_pend & wr_byte[0],
        {8{wr_pin_pend}} & wr_byte
    };

    // set wins over a clear in the same cycle
    assign pend_all = {ext_pin_irq_pending, pin_irq_pending};
    assign next_pend_all = (pend_all & ~pend_clear) | (edge_hit & irq_allowed);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_irq_pending <= `FPGIO_RST_BYTE;
            ext_pin_irq_pending <= `FPGIO_RST_BIT;
        end else begin
            pin_irq_pending <= next_pend_all[7:0];
            ext_pin_irq_pending <= next_pend_all[`FPGIO_EXT_BIT];
        end
    end

    // request follows pending and enable, one edge later
    assign enable_all = {ext_pin_irq_enable, pin_irq_enable};

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(pend_all & enable_all);
        end
    end

    // pin drivers registered so the pads see clean levels
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            protect_pin_drive_o <= 4'h0;
            protect_pin_oe_o <= 4'h0;
            general_pin_drive_o <= 4'h0;
            general_pin_oe_o <= 4'h0;
            external_irq_pin_drive_o <= 1'b0;
            external_irq_pin_oe_o <= 1'b0;
        end else begin
            protect_pin_drive_o <= pin_output_value[3:0];
            protect_pin_oe_o <= pin_direction[3:0];
            general_pin_drive_o <= pin_output_value[7:4];
            general_pin_oe_o <= pin_direction[7:4] & general_pin_gp_mode_i;
            external_irq_pin_drive_o <= ext_pin_output_value;
            external_irq_pin_oe_o <= ext_pin_direction;
        end
    end

endmodule // fpgio_top

`default_nettype wire

/* File: sim/fpgio_pin_model.sv */
`default_nettype none

module fpgio_pin_model (
    // device side: bit 8 external, 7..4 general d..a, 3..0 protect
    input wire logic [8:0] drive_i,
    input wire logic [8:0] oe_i,
    // outside source, overridden wherever the device drives
    input wire logic [8:0] ext_i,
    output logic [8:0] level_o
);
    timeunit 1ns;
    timeprecision 100ps;
    assign level_o = (oe_i & drive_i) | (~oe_i & ext_i);
endmodule // fpgio_pin_model

`default_nettype wire

/* File: sim/fpgio_top_chk.sv */
`default_nettype none

module fpgio_top_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // bus
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // pins and request
    input wire logic [3:0] protect_pin_oe_o,
    input wire logic [3:0] general_pin_gp_mode_i,
    input wire logic [3:0] general_pin_oe_o,
    input wire logic external_irq_pin_oe_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped early");
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##2 s_axi_bvalid_o) else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##2 s_axi_rvalid_o)
        else $error("read data late");
    a_read_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read taken while busy");
    a_write_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while busy");
    a_general_oe_mode: assert property ((general_pin_oe_o & ~$past(general_pin_gp_mode_i)) == 4'h0)
        else $error("general pin driven outside general mode");
    a_protect_oe_cause: assert property ($changed(protect_pin_oe_o) |-> $past(s_axi_bvalid_o, 2))
        else $error("protect enable moved without a write");
    a_ext_oe_cause: assert property ($changed(external_irq_pin_oe_o) |-> $past(s_axi_bvalid_o, 2))
        else $error("external enable moved without a write");
    a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(s_axi_bvalid_o, 2))
        else $error("request fell without a write");
endmodule // fpgio_top_chk

bind fpgio_top fpgio_top_chk i_chk (.clk_i, .rst_b_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .protect_pin_oe_o, .general_pin_gp_mode_i,
    .general_pin_oe_o, .external_irq_pin_oe_o, .irq_o);

`default_nettype wire

/* File: sim/tb_top.sv */
`include "fpgio_consts.svh"

`default_nettype none

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end

module tb_top
    import fpgio_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, rst_b_i, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic xd, xo, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic [3:0] wstrb, gp_mode, pd, po, gd, go, s;
    logic [1:0] bresp, rresp;
    logic [8:0] ext_lvl, lvl, e;
    int mismatches, comparisons, cyc, k;
    fpgio_byte_t sh [8];
    // first eight are read-write, in shadow order
    logic [31:0] ra [12] = '{`FPGIO_ADDR_PIN_DIR, `FPGIO_ADDR_PIN_OUT, `FPGIO_ADDR_PIN_IRQ_EN, `FPGIO_ADDR_PIN_EDGE,
        `FPGIO_ADDR_EXT_DIR, `FPGIO_ADDR_EXT_OUT, `FPGIO_ADDR_EXT_IRQ_EN, `FPGIO_ADDR_EXT_EDGE,
        `FPGIO_ADDR_PIN_LEVEL, `FPGIO_ADDR_EXT_LEVEL, `FPGIO_ADDR_PIN_PEND, `FPGIO_ADDR_EXT_PEND};

    fpgio_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .protect_pin_level_i(lvl[3:0]), .protect_pin_drive_o(pd), .protect_pin_oe_o(po),
        .general_pin_level_i(lvl[7:4]), .general_pin_gp_mode_i(gp_mode), .general_pin_drive_o(gd),
        .general_pin_oe_o(go), .external_irq_pin_level_i(lvl[8]), .external_irq_pin_drive_o(xd),
        .external_irq_pin_oe_o(xo), .irq_o(irq));
    fpgio_pin_model i_pins (.drive_i({xd, gd, pd}), .oe_i({xo, go, po}), .ext_i(ext_lvl), .level_o(lvl));

    task automatic end_sim();
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] dv, input logic [3:0] sv, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= dv;
        wstrb <= sv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_i);
            if (awvalid && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk_i);
        `CHK("bresp", er, bresp)
        bready <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] ev, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk_i);
        `CHK("rdata", ev, rdata)
        `CHK("rresp", er, rresp)
        rready <= 1'b0;
        @(posedge clk_i);
    endtask

    // wire level where the device drives, outside source elsewhere
    function automatic logic [8:0] wire_exp(input logic [3:0] gm, input logic [8:0] ext);
        logic [8:0] oe;
        oe = {sh[4][0], sh[0][7:4] & gm, sh[0][3:0]};
        return (oe & {sh[5][0], sh[1]}) | (~oe & ext);
    endfunction

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        {rst_b_i, awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, araddr, wstrb} = '0;
        {gp_mode, ext_lvl, mismatches, comparisons, cyc} = '0;
        sh = '{default: 8'h00};
        void'($urandom(32'hDF7B));
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        wr(ra[8], 32'hFF, 4'hF, FPGIO_RESP_OKAY);
        wr(32'hFFF7FA0C, 32'hFF, 4'hF, FPGIO_RESP_SLVERR);
        rd(32'hFFF7FA0C, 32'h0, FPGIO_RESP_SLVERR);
        foreach (ra[i]) rd(ra[i], 32'h0, FPGIO_RESP_OKAY);
        repeat (40) begin
            k = $urandom_range(7);
            d = $urandom();
            s = $urandom();
            wr(ra[k], d, s, FPGIO_RESP_OKAY);
            if (s[0]) sh[k] = d[7:0] & (k < 4 ? 8'hFF : 8'h01);
            gp_mode <= $urandom();
            ext_lvl <= $urandom();
            rd(ra[k], {24'h0, sh[k]}, FPGIO_RESP_OKAY);
            e = wire_exp(gp_mode, ext_lvl);
            `CHK("pin wires", e, lvl)
            `CHK("protect oe", sh[0][3:0], po)
            `CHK("general oe", sh[0][7:4] & gp_mode, go)
            `CHK("external oe", sh[4][0], xo)
            rd(ra[8], {24'h0, e[7:0]}, FPGIO_RESP_OKAY);
            rd(ra[9], {31'h0, e[8]}, FPGIO_RESP_OKAY);
        end
        for (int p = 0; p < 2; p++) begin
            wr(ra[0], 32'h0, 4'hF, FPGIO_RESP_OKAY);
            wr(ra[4], 32'h0, 4'hF, FPGIO_RESP_OKAY);
            wr(ra[2], 32'h0, 4'hF, FPGIO_RESP_OKAY);
            wr(ra[6], 32'h0, 4'hF, FPGIO_RESP_OKAY);
            wr(ra[3], {24'h0, {8{p[0]}}}, 4'h1, FPGIO_RESP_OKAY);
            wr(ra[7], p, 4'h1, FPGIO_RESP_OKAY);
            gp_mode <= p ? 4'hF : 4'h0;
            ext_lvl <= {9{~p[0]}};
            repeat (6) @(posedge clk_i);
            wr(ra[10], 32'hFF, 4'h1, FPGIO_RESP_OKAY);
            wr(ra[11], 32'h1, 4'h1, FPGIO_RESP_OKAY);
            // general pins outside general mode on the first pass must stay quiet
            e = p ? 9'h0FF : 9'h03C;
            wr(ra[2], e, 4'h1, FPGIO_RESP_OKAY);
            wr(ra[6], p, 4'h1, FPGIO_RESP_OKAY);
            ext_lvl <= {9{p[0]}};
            repeat (6) @(posedge clk_i);
            e[7:0] = e[7:0] & (p ? 8'hFF : 8'h0F);
            `CHK("irq set", (|e[7:0]) | p[0], irq)
            rd(ra[10], {24'h0, e[7:0]}, FPGIO_RESP_OKAY);
            rd(ra[11], p, FPGIO_RESP_OKAY);
            wr(ra[10], 32'h0, 4'h1, FPGIO_RESP_OKAY);
            rd(ra[10], {24'h0, e[7:0]}, FPGIO_RESP_OKAY);
            wr(ra[10], 32'h55, 4'h1, FPGIO_RESP_OKAY);
            rd(ra[10], {24'h0, e[7:0] & 8'hAA}, FPGIO_RESP_OKAY);
            wr(ra[10], 32'hFF, 4'h1, FPGIO_RESP_OKAY);
            wr(ra[11], 32'h1, 4'h1, FPGIO_RESP_OKAY);
            ext_lvl <= {9{~p[0]}};
            repeat (6) @(posedge clk_i);
            rd(ra[10], 32'h0, FPGIO_RESP_OKAY);
            rd(ra[11], 32'h0, FPGIO_RESP_OKAY);
            `CHK("irq clear", 1'b0, irq)
        end
        end_sim();
    end
endmodule // tb_top

`default_nettype wire
